// ==== core/rxp_fifo.sv ====
`timescale 1ns/1ps
`include "rxp_defs.svh"

module rxp_fifo #(
   parameter int DEPTH = `RXP_FIFO_DEPTH,
   parameter int AW = `RXP_FIFO_AW
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_valid,
   input wire logic [`RXP_DATA_W-1:0] wr_word,
   input wire logic [`RXP_BE_W-1:0] wr_be,
   input wire logic wr_portid,
   input wire logic wr_sop,
   input wire logic wr_eop,
   input wire logic wr_err,
   output logic wr_ready,
   input wire logic rd_clk,
   input wire logic rd_en,
   input wire logic [`RXP_RADDR_W-1:0] rd_addr,
   input wire logic halt_at_end,
   input wire logic empty_kind,
   output logic [`RXP_DATA_W-1:0] rd_word,
   output logic [`RXP_BE_W-1:0] rd_be,
   output logic rd_portid,
   output logic rd_sop,
   output logic rd_eop,
   output logic rd_err,
   output logic empty_flag,
   output logic [AW:0] level,
   output logic ev_underrun,
   output logic ev_errword
);
   localparam int EW = `RXP_DATA_W + `RXP_BE_W + 4;
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] QUARTER_M1 = (AW+1)'(DEPTH / 4 - 1);

   logic [EW-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic rd_clk_q;
   logic halted;

   wire rd_edge = rd_clk & ~rd_clk_q;
   wire true_empty = (level == '0);
   wire push = wr_valid & wr_ready;
   // no advance while empty or held after an end word
   wire pop = rd_edge & rd_en & ~true_empty & ~halted;
   wire [AW-1:0] peek_ptr = rd_ptr + AW'(rd_addr);
   wire [EW-1:0] peek = mem[peek_ptr];
   wire [AW:0] next_level = level + (AW+1)'(push) - (AW+1)'(pop);
   wire next_true_empty = (next_level == '0);
   wire next_quarter_low = (next_level <= QUARTER_M1);
   // kind 0: truly empty; kind 1: at quarter full minus one or less
   wire next_empty = empty_kind ? next_quarter_low : next_true_empty;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= {wr_word, wr_be, wr_portid, wr_sop, wr_eop, wr_err};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
         rd_clk_q <= 1'b0;
         halted <= 1'b0;
         wr_ready <= 1'b1;
         empty_flag <= 1'b1;
         ev_underrun <= 1'b0;
         ev_errword <= 1'b0;
      end else begin
         rd_clk_q <= rd_clk;
         level <= next_level;
         wr_ready <= (next_level != FULL);
         empty_flag <= next_empty;
         ev_underrun <= rd_edge & rd_en & true_empty;
         ev_errword <= pop & peek[0];
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         // hold after an end word until the reader drops its enable
         if (!rd_en) begin
            halted <= 1'b0;
         end else if (pop && halt_at_end && peek[1]) begin
            halted <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_word <= '0;
         rd_be <= '0;
         rd_portid <= 1'b0;
         rd_sop <= 1'b0;
         rd_eop <= 1'b0;
         rd_err <= 1'b0;
      end else if (pop) begin
         rd_word <= peek[EW-1 -: `RXP_DATA_W];
         rd_be <= peek[EW-1-`RXP_DATA_W -: `RXP_BE_W];
         rd_portid <= peek[3];
         rd_sop <= peek[2];
         rd_eop <= peek[1];
         rd_err <= peek[0];
      end
   end
endmodule

// ==== core/rxp_top.sv ====
// Function
// - four byte enables per read word, bit 3 for 31:24 down to bit 0 for 7:0.
// - port-id flag high when the read word is a port identifier.
// - start marker is 1 on the first word of a packet.
// - end marker is 1 on the last word of a packet.
// - error marker is 1 while the presented word is flagged bad.
// - empty-kind select 0 (reset default) gives a truly-empty flag.
// - empty-kind select 1 flags empty at quarter full minus one or less.
// - user port index is the status ram write address.
// - status ram stores only while the user write enable is high.
// - status ram writes follow the user write clock.
// - external status enable sends user status instead of internal status.
// - delay-line enable only for static capture; user holds 0 otherwise.
// - delay-line enable 0 bypasses the data clock delay, 1 inserts it.
// - status clock is the receive data clock divided by four.
`timescale 1ns/1ps
`include "rxp_defs.svh"

module rxp_top #(
   parameter int DEPTH = `RXP_FIFO_DEPTH,
   parameter int AW = `RXP_FIFO_AW
) (
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic irq,
   // link-side fill of fifo 2 and 3
   input wire logic rx_fifo2_fill_valid,
   input wire logic [`RXP_DATA_W-1:0] rx_fifo2_fill_word,
   input wire logic [`RXP_BE_W-1:0] rx_fifo2_fill_be,
   input wire logic rx_fifo2_fill_portid,
   input wire logic rx_fifo2_fill_sop,
   input wire logic rx_fifo2_fill_eop,
   input wire logic rx_fifo2_fill_err,
   output logic rx_fifo2_fill_ready,
   input wire logic rx_fifo3_fill_valid,
   input wire logic [`RXP_DATA_W-1:0] rx_fifo3_fill_word,
   input wire logic [`RXP_BE_W-1:0] rx_fifo3_fill_be,
   input wire logic rx_fifo3_fill_portid,
   input wire logic rx_fifo3_fill_sop,
   input wire logic rx_fifo3_fill_eop,
   input wire logic rx_fifo3_fill_err,
   output logic rx_fifo3_fill_ready,
   // user read port of fifo 2
   input wire logic [`RXP_RADDR_W-1:0] rx_fifo2_read_addr,
   input wire logic rx_fifo2_rd_clk,
   input wire logic rx_fifo2_rd_en,
   input wire logic rx_fifo2_halt_at_end,
   output logic [`RXP_DATA_W-1:0] rx_fifo2_read_word,
   output logic [`RXP_BE_W-1:0] rx_fifo2_byte_en,
   output logic rx_fifo2_portid_flag,
   output logic rx_fifo2_pkt_start,
   output logic rx_fifo2_pkt_end,
   output logic rx_fifo2_word_err,
   output logic rx_fifo2_empty_flag,
   // user read port of fifo 3
   input wire logic [`RXP_RADDR_W-1:0] rx_fifo3_read_addr,
   input wire logic rx_fifo3_rd_clk,
   input wire logic rx_fifo3_rd_en,
   input wire logic rx_fifo3_halt_at_end,
   output logic [`RXP_DATA_W-1:0] rx_fifo3_read_word,
   output logic [`RXP_BE_W-1:0] rx_fifo3_byte_en,
   output logic rx_fifo3_portid_flag,
   output logic rx_fifo3_pkt_start,
   output logic rx_fifo3_pkt_end,
   output logic rx_fifo3_word_err,
   output logic rx_fifo3_empty_flag,
   // status write port and status channel
   input wire logic [`RXP_PORT_W-1:0] status_port_index,
   input wire logic [`RXP_STAT_W-1:0] status_value_in,
   input wire logic external_status_enable,
   input wire logic status_ram_write_en,
   input wire logic status_ram_write_clk,
   input wire logic [`RXP_PORT_W-1:0] status_poll_index,
   output rxp_pkg::rxp_status_t link_status,
   // receive clock path controls
   input wire logic rx_data_clk,
   input wire logic clock_delay_line_enable,
   input wire logic [`RXP_TAP_W-1:0] clock_delay_tap_select,
   output logic clock_delay_inserted,
   output logic [`RXP_TAP_W-1:0] clock_delay_tap,
   output logic rx_status_quarter_clk
);
   logic [`RXP_IRQ_WIDTH-1:0] irq_status;
   logic [`RXP_IRQ_WIDTH-1:0] irq_enable;
   logic [1:0] config_bits;
   logic [`RXP_STAT_W-1:0] status_ram [`RXP_PORTS];
   logic [`RXP_STAT_W-1:0] status_ram_rd;
   logic stat_clk_q;
   logic data_clk_q;
   logic div_cnt;
   logic [AW:0] level2;
   logic [AW:0] level3;
   logic underrun2;
   logic underrun3;
   logic errword2;
   logic errword3;

   rxp_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo2 (
      .clk(clk),
      .rst(rst),
      .wr_valid(rx_fifo2_fill_valid),
      .wr_word(rx_fifo2_fill_word),
      .wr_be(rx_fifo2_fill_be),
      .wr_portid(rx_fifo2_fill_portid),
      .wr_sop(rx_fifo2_fill_sop),
      .wr_eop(rx_fifo2_fill_eop),
      .wr_err(rx_fifo2_fill_err),
      .wr_ready(rx_fifo2_fill_ready),
      .rd_clk(rx_fifo2_rd_clk),
      .rd_en(rx_fifo2_rd_en),
      .rd_addr(rx_fifo2_read_addr),
      .halt_at_end(rx_fifo2_halt_at_end),
      .empty_kind(config_bits[`RXP_CFG_EMPTY_KIND2]),
      .rd_word(rx_fifo2_read_word),
      .rd_be(rx_fifo2_byte_en),
      .rd_portid(rx_fifo2_portid_flag),
      .rd_sop(rx_fifo2_pkt_start),
      .rd_eop(rx_fifo2_pkt_end),
      .rd_err(rx_fifo2_word_err),
      .empty_flag(rx_fifo2_empty_flag),
      .level(level2),
      .ev_underrun(underrun2),
      .ev_errword(errword2)
   );

   rxp_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo3 (
      .clk(clk),
      .rst(rst),
      .wr_valid(rx_fifo3_fill_valid),
      .wr_word(rx_fifo3_fill_word),
      .wr_be(rx_fifo3_fill_be),
      .wr_portid(rx_fifo3_fill_portid),
      .wr_sop(rx_fifo3_fill_sop),
      .wr_eop(rx_fifo3_fill_eop),
      .wr_err(rx_fifo3_fill_err),
      .wr_ready(rx_fifo3_fill_ready),
      .rd_clk(rx_fifo3_rd_clk),
      .rd_en(rx_fifo3_rd_en),
      .rd_addr(rx_fifo3_read_addr),
      .halt_at_end(rx_fifo3_halt_at_end),
      .empty_kind(config_bits[`RXP_CFG_EMPTY_KIND3]),
      .rd_word(rx_fifo3_read_word),
      .rd_be(rx_fifo3_byte_en),
      .rd_portid(rx_fifo3_portid_flag),
      .rd_sop(rx_fifo3_pkt_start),
      .rd_eop(rx_fifo3_pkt_end),
      .rd_err(rx_fifo3_word_err),
      .empty_flag(rx_fifo3_empty_flag),
      .level(level3),
      .ev_underrun(underrun3),
      .ev_errword(errword3)
   );

   // status ram: write on a rising edge of the user write clock, enable high
   wire stat_wr_edge = status_ram_write_clk & ~stat_clk_q;
   wire stat_write = stat_wr_edge & status_ram_write_en;

   always_ff @(posedge clk) begin
      if (stat_write) begin
         status_ram[status_port_index] <= status_value_in;
      end
   end

   // quarter-rate clock from the receive data clock
   wire data_clk_edge = rx_data_clk & ~data_clk_q;
   wire quarter_toggle = data_clk_edge & (div_cnt == `RXP_CLK_DIV_HALF);
   wire quarter_rise = quarter_toggle & ~rx_status_quarter_clk;

   // internal status follows the polled fifo fill; fifo 3 takes odd ports
   wire poll_fifo3 = status_poll_index[0];
   wire [AW:0] poll_level = poll_fifo3 ? level3 : level2;
   wire [AW:0] full_level = (AW+1)'(DEPTH);
   wire [AW:0] half_level = (AW+1)'(DEPTH / 2);
   wire poll_full = (poll_level == full_level);
   wire poll_half = (poll_level >= half_level);
   wire [`RXP_STAT_W-1:0] internal_status = poll_full ? rxp_pkg::RXP_STAT_SATISFIED :
      (poll_half ? rxp_pkg::RXP_STAT_HUNGRY : rxp_pkg::RXP_STAT_STARVING);
   wire [`RXP_STAT_W-1:0] next_status =
      external_status_enable ? status_ram_rd : internal_status;

   // tap 7 is invalid; clamp so the delay line never sees it
   wire tap_bad = (clock_delay_tap_select > `RXP_TAP_MAX);
   wire [`RXP_TAP_W-1:0] tap_safe = tap_bad ? `RXP_TAP_MAX : clock_delay_tap_select;

   // register decode
   wire sel_status = (reg_addr == `RXP_REG_IRQ_STATUS);
   wire sel_clear = (reg_addr == `RXP_REG_IRQ_CLEAR);
   wire sel_enable = (reg_addr == `RXP_REG_IRQ_ENABLE);
   wire sel_config = (reg_addr == `RXP_REG_CONFIG);
   wire sel_levels = (reg_addr == `RXP_REG_LEVELS);
   wire [31:0] levels_word = (32'(level3) << `RXP_LEVEL_POS3) | 32'(level2);
   wire [31:0] read_mux = sel_status ? 32'(irq_status) :
      sel_enable ? 32'(irq_enable) :
      sel_config ? 32'(config_bits) :
      sel_levels ? levels_word : 32'h0000_0000;
   wire [`RXP_IRQ_WIDTH-1:0] events = {stat_write, tap_bad & clock_delay_line_enable,
      errword3, errword2, underrun3, underrun2};
   wire [`RXP_IRQ_WIDTH-1:0] clear_mask =
      (reg_write && sel_clear) ? reg_wdata[`RXP_IRQ_WIDTH-1:0] : '0;
   // a new event wins over a clear in the same cycle
   wire [`RXP_IRQ_WIDTH-1:0] next_irq_status = (irq_status & ~clear_mask) | events;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= '0;
         irq_enable <= '0;
         config_bits <= `RXP_CFG_RESET;
         reg_rdata <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_enable);
         reg_rdata <= reg_read ? read_mux : 32'h0000_0000;
         if (reg_write && sel_enable) begin
            irq_enable <= reg_wdata[`RXP_IRQ_WIDTH-1:0];
         end
         if (reg_write && sel_config) begin
            config_bits <= reg_wdata[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stat_clk_q <= 1'b0;
         data_clk_q <= 1'b0;
         div_cnt <= 1'b0;
         rx_status_quarter_clk <= 1'b0;
         status_ram_rd <= '0;
         link_status <= rxp_pkg::RXP_STAT_STARVING;
         clock_delay_inserted <= 1'b0;
         clock_delay_tap <= '0;
      end else begin
         stat_clk_q <= status_ram_write_clk;
         data_clk_q <= rx_data_clk;
         status_ram_rd <= status_ram[status_poll_index];
         if (data_clk_edge) begin
            div_cnt <= ~div_cnt;
         end
         if (quarter_toggle) begin
            rx_status_quarter_clk <= ~rx_status_quarter_clk;
         end
         // status channel updates only on the quarter-rate clock
         if (quarter_rise) begin
            link_status <= rxp_pkg::rxp_status_t'(next_status);
         end
         // dynamic alignment relies on the user holding the enable low
         clock_delay_inserted <= clock_delay_line_enable;
         clock_delay_tap <= clock_delay_line_enable ? tap_safe : '0;
      end
   end
endmodule

// ==== include/rxp_defs.svh ====
`ifndef RXP_DEFS_SVH
`define RXP_DEFS_SVH

// register byte addresses
`define RXP_REG_IRQ_STATUS 8'h00
`define RXP_REG_IRQ_CLEAR 8'h04
`define RXP_REG_IRQ_ENABLE 8'h08
`define RXP_REG_CONFIG 8'h0c
`define RXP_REG_LEVELS 8'h10

// interrupt status / clear / enable layout
`define RXP_IRQ_WIDTH 6
`define RXP_IRQ_UNDERRUN2 0
`define RXP_IRQ_UNDERRUN3 1
`define RXP_IRQ_ERRWORD2 2
`define RXP_IRQ_ERRWORD3 3
`define RXP_IRQ_BADTAP 4
`define RXP_IRQ_STATWR 5

// config layout: one empty-kind select bit per fifo
`define RXP_CFG_EMPTY_KIND2 0
`define RXP_CFG_EMPTY_KIND3 1
`define RXP_CFG_RESET 2'h0

// fifo geometry
`define RXP_FIFO_DEPTH 64
`define RXP_FIFO_AW 6
`define RXP_DATA_W 32
`define RXP_BE_W 4
`define RXP_RADDR_W 3
`define RXP_LEVEL_POS3 16

// status channel
`define RXP_PORT_W 8
`define RXP_PORTS 256
`define RXP_STAT_W 2
`define RXP_CLK_DIV_HALF 1'h1
`define RXP_TAP_W 3
`define RXP_TAP_MAX 3'h6

`endif

// ==== include/rxp_pkg.sv ====
package rxp_pkg;
   typedef enum logic [1:0] {
      RXP_STAT_STARVING = 2'b00,
      RXP_STAT_HUNGRY = 2'b01,
      RXP_STAT_SATISFIED = 2'b10,
      RXP_STAT_FRAMING = 2'b11
   } rxp_status_t;
endpackage

// ==== sim/rxp_top_sva.sv ====
`timescale 1ns/1ps
module rxp_top_sva (
   input logic clk,
   input logic rst,
   input logic reg_read,
   input logic [31:0] reg_rdata,
   input logic rx_fifo2_fill_ready,
   input logic rx_fifo2_rd_clk,
   input logic rx_fifo2_rd_en,
   input logic [31:0] rx_fifo2_read_word,
   input logic rx_fifo2_empty_flag,
   input logic rx_fifo3_empty_flag,
   input logic rx_fifo3_rd_clk,
   input logic rx_fifo3_rd_en,
   input logic rx_fifo3_word_err,
   input rxp_pkg::rxp_status_t link_status,
   input logic rx_status_quarter_clk,
   input logic clock_delay_line_enable,
   input logic [2:0] clock_delay_tap_select,
   input logic clock_delay_inserted,
   input logic [2:0] clock_delay_tap
);
   logic q1, q2;
   always_ff @(posedge clk) begin
      q1 <= rx_status_quarter_clk;
      q2 <= q1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   reset_state_a: assert property ($fell(rst) |-> rx_fifo2_empty_flag &&
      rx_fifo3_empty_flag && rx_fifo2_fill_ready && link_status == 2'b00)
      else $error("wrong state after reset");
   read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   word_hold_a: assert property ($changed(rx_fifo2_read_word) |->
      $past(rx_fifo2_rd_clk && rx_fifo2_rd_en) && !$past(rx_fifo2_rd_clk, 2))
      else $error("read word moved without a read");
   err_cause_a: assert property ($rose(rx_fifo3_word_err) |->
      $past(rx_fifo3_rd_clk && rx_fifo3_rd_en)) else $error("error marker without a read");
   quarter_period_a: assert property ($changed(rx_status_quarter_clk) |=>
      $stable(rx_status_quarter_clk)[*7]) else $error("status clock not data clock by four");
   status_update_a: assert property ($changed(link_status) |->
      (q1 && !q2) || (rx_status_quarter_clk && !q1)) else $error("status off the quarter clock");
   bypass_tap_a: assert property (!clock_delay_inserted |-> clock_delay_tap == 3'h0)
      else $error("tap used while bypassed");
   delay_follow_a: assert property ($past(clock_delay_line_enable) &&
      $past(clock_delay_tap_select) != 3'h7 |-> clock_delay_inserted &&
      clock_delay_tap == $past(clock_delay_tap_select)) else $error("delay line not applied");
   tap_range_a: assert property (clock_delay_tap != 3'h7)
      else $error("invalid tap applied");
   cover property (rx_fifo2_rd_clk && rx_fifo2_rd_en && !rx_fifo2_empty_flag);
   cover property ($changed(link_status));
   cover property ($rose(clock_delay_inserted));
endmodule

// ==== sim/rxp_user_model.sv ====
`timescale 1ns/1ps
module rxp_user_model (
   input logic clk,
   input logic [1:0] pop_req,
   output logic rx_fifo2_rd_clk,
   output logic rx_fifo2_rd_en,
   output logic rx_fifo3_rd_clk,
   output logic rx_fifo3_rd_en
);
   // one read clock high phase per request; enable framed by it
   initial {rx_fifo2_rd_clk, rx_fifo2_rd_en, rx_fifo3_rd_clk, rx_fifo3_rd_en} = 4'h0;
   always @(posedge clk) begin
      {rx_fifo2_rd_clk, rx_fifo2_rd_en} <= {2{pop_req[0]}};
      {rx_fifo3_rd_clk, rx_fifo3_rd_en} <= {2{pop_req[1]}};
   end
endmodule

// ==== sim/test_rxp_top.sv ====
`timescale 1ns/1ps
module test_rxp_top;
   localparam int DEPTH = 8;
   localparam int AW = 3;
   logic clk, rst, reg_write, reg_read, irq;
   logic [7:0] reg_addr, status_port_index, status_poll_index;
   logic [31:0] reg_wdata, reg_rdata, rx_fifo2_fill_word, rx_fifo3_fill_word;
   logic [31:0] rx_fifo2_read_word, rx_fifo3_read_word;
   logic [3:0] rx_fifo2_fill_be, rx_fifo3_fill_be, rx_fifo2_byte_en, rx_fifo3_byte_en;
   logic rx_fifo2_fill_valid, rx_fifo2_fill_portid, rx_fifo2_fill_sop, rx_fifo2_fill_eop;
   logic rx_fifo3_fill_valid, rx_fifo3_fill_portid, rx_fifo3_fill_sop, rx_fifo3_fill_eop;
   logic rx_fifo2_fill_err, rx_fifo3_fill_err, rx_fifo2_fill_ready, rx_fifo3_fill_ready;
   logic [2:0] rx_fifo2_read_addr, rx_fifo3_read_addr, clock_delay_tap_select, clock_delay_tap;
   logic rx_fifo2_rd_clk, rx_fifo2_rd_en, rx_fifo2_halt_at_end, rx_fifo2_portid_flag;
   logic rx_fifo3_rd_clk, rx_fifo3_rd_en, rx_fifo3_halt_at_end, rx_fifo3_portid_flag;
   logic rx_fifo2_pkt_start, rx_fifo2_pkt_end, rx_fifo2_word_err, rx_fifo2_empty_flag;
   logic rx_fifo3_pkt_start, rx_fifo3_pkt_end, rx_fifo3_word_err, rx_fifo3_empty_flag;
   logic [1:0] status_value_in, pop_req;
   logic external_status_enable, status_ram_write_en, status_ram_write_clk, rx_data_clk;
   logic clock_delay_line_enable, clock_delay_inserted, rx_status_quarter_clk;
   rxp_pkg::rxp_status_t link_status;
   int failures, checks, cyc;

   rxp_top #(.DEPTH(DEPTH), .AW(AW)) u_rxp_top (.*);
   rxp_user_model u_rxp_user_model (.*);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // data clock of four system cycles keeps the quarter clock period checkable
   initial forever begin
      repeat (2) @(posedge clk);
      rx_data_clk <= ~rx_data_clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      checks++;
      if (g !== e) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         failures++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
      @(posedge clk);
      reg_write <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      {reg_addr, reg_read} <= {a, 1'b1};
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   task automatic push(input int f, input logic [39:0] v);
      if (f == 3) {rx_fifo3_fill_valid, rx_fifo3_fill_word, rx_fifo3_fill_be,
         rx_fifo3_fill_portid, rx_fifo3_fill_sop, rx_fifo3_fill_eop, rx_fifo3_fill_err} <= {1'b1, v};
      else {rx_fifo2_fill_valid, rx_fifo2_fill_word, rx_fifo2_fill_be,
         rx_fifo2_fill_portid, rx_fifo2_fill_sop, rx_fifo2_fill_eop, rx_fifo2_fill_err} <= {1'b1, v};
      @(posedge clk);
      {rx_fifo2_fill_valid, rx_fifo3_fill_valid} <= 2'b00;
      tick(1);
   endtask
   task automatic pop(input int f, input logic [39:0] e);
      pop_req[f-2] <= 1'b1;
      @(posedge clk);
      pop_req <= 2'b00;
      tick(1);
      if (f == 3) chk({rx_fifo3_read_word, rx_fifo3_byte_en, rx_fifo3_portid_flag,
         rx_fifo3_pkt_start, rx_fifo3_pkt_end, rx_fifo3_word_err}, e);
      else chk({rx_fifo2_read_word, rx_fifo2_byte_en, rx_fifo2_portid_flag,
         rx_fifo2_pkt_start, rx_fifo2_pkt_end, rx_fifo2_word_err}, e);
   endtask
   task automatic sw(input logic [7:0] idx, input logic [1:0] v, input logic we);
      {status_port_index, status_value_in, status_ram_write_en} <= {idx, v, we};
      @(posedge clk);
      status_ram_write_clk <= 1'b1;
      @(posedge clk);
      {status_ram_write_clk, status_ram_write_en} <= 2'b00;
      tick(24);
   endtask

   task automatic t_reset();
      chk({rx_fifo2_empty_flag, rx_fifo3_empty_flag, rx_fifo2_fill_ready, rx_fifo3_fill_ready,
         link_status, irq}, 7'h78);
      wr(8'h40, 32'hff);
      rd(8'h40, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h0c, 32'h0);
      wr(8'h0c, 32'h3);
      rd(8'h0c, 32'h3);
      wr(8'h0c, 32'h0);
   endtask
   task automatic t_packet();
      logic [39:0] w [4];
      w = '{{32'h11, 4'hf, 4'h8}, {32'ha1a2a3a4, 4'hf, 4'h4}, {32'hb1b2b3b4, 4'hc, 4'h1},
         {32'hc1c2c3c4, 4'h1, 4'h2}};
      wr(8'h08, 32'h1);
      foreach (w[i]) push(2, w[i]);
      foreach (w[i]) pop(2, w[i]);
      chk(irq, 1'b0);
      pop(2, w[3]);
      tick(1);
      chk(irq, 1'b1);
      rd(8'h00, 32'h5);
      wr(8'h04, 32'h3f);
      chk(irq, 1'b0);
      // offset read shows head plus one, then the head moves by one only
      push(2, {32'h21, 4'hf, 4'h0});
      push(2, {32'h22, 4'h3, 4'h0});
      rx_fifo2_read_addr <= 3'h1;
      pop(2, {32'h22, 4'h3, 4'h0});
      rx_fifo2_read_addr <= 3'h0;
      pop(2, {32'h22, 4'h3, 4'h0});
   endtask
   task automatic t_empty_kind();
      wr(8'h0c, 32'h2);
      push(3, {32'h5, 4'hf, 4'h4});
      chk(rx_fifo3_empty_flag, 1'b1);
      push(3, {32'h6, 4'h7, 4'h3});
      chk(rx_fifo3_empty_flag, 1'b0);
      rd(8'h10, 32'h0002_0000);
      wr(8'h0c, 32'h0);
      chk(rx_fifo3_empty_flag, 1'b0);
      pop(3, {32'h5, 4'hf, 4'h4});
      pop(3, {32'h6, 4'h7, 4'h3});
      chk(rx_fifo3_empty_flag, 1'b1);
   endtask
   task automatic t_status();
      {external_status_enable, status_poll_index} <= {1'b1, 8'h05};
      sw(8'h05, 2'b11, 1'b1);
      chk(link_status, 2'b11);
      sw(8'h05, 2'b01, 1'b0);
      chk(link_status, 2'b11);
      sw(8'h06, 2'b01, 1'b1);
      chk(link_status, 2'b11);
      status_poll_index <= 8'h06;
      tick(24);
      chk(link_status, 2'b01);
      // internal status of an empty fifo 2 replaces the stored 01
      external_status_enable <= 1'b0;
      tick(24);
      chk(link_status, 2'b00);
   endtask
   task automatic t_delay();
      {clock_delay_line_enable, clock_delay_tap_select} <= {1'b1, 3'h3};
      tick(2);
      chk({clock_delay_inserted, clock_delay_tap}, 4'hb);
      clock_delay_tap_select <= 3'h7;
      tick(2);
      chk({clock_delay_inserted, clock_delay_tap}, 4'he);
      clock_delay_line_enable <= 1'b0;
      tick(2);
      chk({clock_delay_inserted, clock_delay_tap}, 4'h0);
      // error word of fifo 3, status write and bad tap since the last clear
      rd(8'h00, 32'h0000_0038);
   endtask

   initial begin
      {rst, reg_addr, reg_wdata, reg_write, reg_read} = {1'b1, 42'h0};
      {rx_fifo2_fill_valid, rx_fifo2_fill_word, rx_fifo2_fill_be, rx_fifo2_fill_portid} = '0;
      {rx_fifo3_fill_valid, rx_fifo3_fill_word, rx_fifo3_fill_be, rx_fifo3_fill_portid} = '0;
      {rx_fifo2_fill_sop, rx_fifo2_fill_eop, rx_fifo2_fill_err, rx_fifo3_fill_sop} = '0;
      {rx_fifo3_fill_eop, rx_fifo3_fill_err, pop_req, rx_data_clk, cyc, failures, checks} = '0;
      // peek offset and halt tied off: halt is never used, one offset 1 read in t_packet
      {rx_fifo2_read_addr, rx_fifo3_read_addr, rx_fifo2_halt_at_end, rx_fifo3_halt_at_end} = '0;
      {status_port_index, status_value_in, external_status_enable, status_poll_index} = '0;
      {status_ram_write_en, status_ram_write_clk, clock_delay_line_enable} = '0;
      clock_delay_tap_select = 3'h0;
      tick(2);
      rst <= 1'b0;
      tick(1);
      t_reset();
      t_packet();
      t_empty_kind();
      t_status();
      t_delay();
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(1);
      t_reset();
      print_verdict();
   end
endmodule

bind rxp_top rxp_top_sva u_rxp_top_sva (.*);
